/* rtl/event_irq_pkg.sv */
// Purpose: Constants and carriers for the event channel interrupt registers
// Assumes: Twelve channels, 32-bit Avalon-MM register slave
// Notes:   Byte offsets are word aligned
package event_irq_pkg;
   localparam int          NUM_CHANNELS     = 12;
   localparam int          ADDR_WIDTH       = 5;
   localparam logic [4:0]  OFFS_ENABLE_CLR  = 5'h10;
   localparam logic [4:0]  OFFS_ENABLE_SET  = 5'h14;
   localparam logic [4:0]  OFFS_FLAGS       = 5'h18;
   localparam logic [31:0] RESET_ENABLE     = 32'h00000000;
   localparam logic [31:0] RESET_FLAGS      = 32'h00000000;
   localparam int          EVD_HI_POS       = 24;
   localparam int          OVR_HI_POS       = 16;
   localparam int          EVD_LO_POS       = 8;
   localparam int          OVR_LO_POS       = 0;
   localparam logic [31:0] USED_BITS_MASK   = 32'h0F0FFFFF;

   typedef struct packed {
      logic [ADDR_WIDTH-1:0] address;
      logic                  read;
      logic                  write;
      logic [31:0]           writedata;
   } bus_req_t;

   typedef struct packed {
      logic [NUM_CHANNELS-1:0] detected;
      logic [NUM_CHANNELS-1:0] overrun;
      logic [NUM_CHANNELS-1:0] asyncPath;
   } chan_events_t;
endpackage : event_irq_pkg

/* rtl/event_channel_irq_regs.sv */
// Purpose: Interrupt enables and flags of a twelve-channel event unit
// Assumes: Event inputs are synchronous to clk, one-cycle pulses
// Notes:   Enable set and clear registers share one enable state
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module event_channel_irq_regs (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // Avalon-MM slave
   input  wire event_irq_pkg::bus_req_t busReq,
   output var  logic [31:0]             readdata,
   output var  logic                    waitrequest,
   // Channel events
   input  wire event_irq_pkg::chan_events_t chanEvents,
   // Interrupt request
   output var  logic                    irqOut
);
   import event_irq_pkg::*;

   logic [31:0] enable_reg;
   logic [31:0] enable_next;
   logic [31:0] flags_reg;
   logic [31:0] flags_next;
   logic [31:0] readdata_reg;
   logic [31:0] readdata_next;
   logic        wait_reg;
   logic        wait_next;
   logic        irq_reg;
   logic        irq_next;
   logic [31:0] setEvents;

   // Refuse any channel count other than the twelve the register layout holds
   generate
      if (NUM_CHANNELS != 12) begin : g_bad_channels
         $error("channel count must be twelve");
      end
   endgenerate

   // One wait state: waitrequest drops in the second request cycle,
   // and a write takes effect at the edge that ends that cycle
   wire         reqActive = busReq.read | busReq.write;
   wire         firstCyc  = reqActive & wait_reg;
   wire         accept    = reqActive & ~wait_reg;
   wire         wrAccept  = accept & busReq.write;
   wire         rdCapture = firstCyc & busReq.read;
   wire [31:0]  wrData    = busReq.writedata & USED_BITS_MASK;
   wire         hitClr    = busReq.address == OFFS_ENABLE_CLR;
   wire         hitSet    = busReq.address == OFFS_ENABLE_SET;
   wire         hitFlags  = busReq.address == OFFS_FLAGS;
   wire [31:0]  wrClr     = (wrAccept & hitClr) ? wrData : 32'h00000000;
   wire [31:0]  wrSet     = (wrAccept & hitSet) ? wrData : 32'h00000000;
   wire [31:0]  wrFlags   = (wrAccept & hitFlags) ? wrData : 32'h00000000;

   // Map per-channel events into register layout
   generate
      for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_map
         localparam int EP = (ch < 8) ? EVD_LO_POS + ch
                                      : EVD_HI_POS + ch - 8;
         localparam int OP = (ch < 8) ? OVR_LO_POS + ch
                                      : OVR_HI_POS + ch - 8;
         assign setEvents[EP] = chanEvents.detected[ch] &
                                ~chanEvents.asyncPath[ch];
         assign setEvents[OP] = chanEvents.overrun[ch] &
                                ~chanEvents.asyncPath[ch];
      end
   endgenerate
   assign setEvents[31:28] = 4'h0;
   assign setEvents[23:20] = 4'h0;

   // Enables: clear wins over set in the same write cycle is moot,
   // the two views never write together
   assign enable_next = (enable_reg | wrSet) & ~wrClr;
   assign flags_next  = (flags_reg & ~wrFlags) | setEvents;
   assign irq_next    = |(flags_next & enable_next);

   wire [31:0] rdMux = (hitClr | hitSet) ? enable_reg :
                       hitFlags          ? flags_reg  : 32'h00000000;
   // Read word is captured in the first cycle and held until the next read
   assign readdata_next = rdCapture ? (rdMux & USED_BITS_MASK)
                                    : readdata_reg;
   assign wait_next     = ~firstCyc;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         enable_reg   <= RESET_ENABLE;
         flags_reg    <= RESET_FLAGS;
         readdata_reg <= 32'h00000000;
         wait_reg     <= 1'b1;
         irq_reg      <= 1'b0;
      end else begin
         enable_reg   <= enable_next;
         flags_reg    <= flags_next;
         readdata_reg <= readdata_next;
         wait_reg     <= wait_next;
         irq_reg      <= irq_next;
      end
   end

   // All outputs come straight from flip-flops
   assign waitrequest = wait_reg;
   assign readdata    = readdata_reg;
   assign irqOut      = irq_reg;

   reserved_zero_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (flags_reg[31:28] == 4'h0) && (flags_reg[23:20] == 4'h0)
      && (enable_reg[31:28] == 4'h0) && (enable_reg[23:20] == 4'h0))
      else $error("reserved bits set");
   event_flag_set_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (|setEvents) |=>
      ((flags_reg & $past(setEvents)) == $past(setEvents)))
      else $error("event flag not set");
   overrun_set_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (chanEvents.overrun[3] && !chanEvents.asyncPath[3]) |=>
      flags_reg[OVR_LO_POS + 3]) else $error("overrun flag not set");
   async_no_set_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!flags_reg[OVR_LO_POS] && chanEvents.asyncPath[0]) |=>
      !flags_reg[OVR_LO_POS]) else $error("async overrun set");
   async_evd_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!flags_reg[EVD_LO_POS] && chanEvents.asyncPath[0]) |=>
      !flags_reg[EVD_LO_POS]) else $error("async event flag set");
   irq_gated_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      irqOut == |(flags_reg & enable_reg))
      else $error("irq not matching enabled flags");
   enable_set_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wrAccept && hitSet && busReq.writedata[EVD_HI_POS]) |=>
      enable_reg[EVD_HI_POS]) else $error("enable set failed");
   overrun_en_set_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wrAccept && hitSet && busReq.writedata[OVR_LO_POS]) |=>
      enable_reg[OVR_LO_POS]) else $error("overrun enable set failed");
   enable_clear_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wrAccept && hitClr && busReq.writedata[OVR_HI_POS]) |=>
      !enable_reg[OVR_HI_POS]) else $error("enable clear failed");
   event_en_clear_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wrAccept && hitClr && busReq.writedata[EVD_LO_POS]) |=>
      !enable_reg[EVD_LO_POS]) else $error("event enable clear failed");
   zero_write_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wrAccept && hitSet && busReq.writedata == 32'h00000000) |=>
      enable_reg == $past(enable_reg)) else $error("zero write changed");
   flag_clear_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wrAccept && hitFlags && busReq.writedata[OVR_LO_POS + 3]
       && !setEvents[OVR_LO_POS + 3]) |=> !flags_reg[OVR_LO_POS + 3])
      else $error("flag clear failed");
   set_beats_clear_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wrAccept && hitFlags && setEvents[EVD_LO_POS + 1]) |=>
      flags_reg[EVD_LO_POS + 1]) else $error("set lost to clear");
   wait_one_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      ($rose(reqActive) && waitrequest) |=> !waitrequest)
      else $error("waitrequest too long");
endmodule : event_channel_irq_regs

`default_nettype wire

/* dv/cpu_bus_model.sv */
// Purpose: Processor model that masters the register bus
// Assumes: Slave answers through waitrequest
// Notes:   Reserved bits are always written as zero
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_model (
   // Clock
   input  wire logic                    clk,
   // Avalon-MM master
   output var  event_irq_pkg::bus_req_t busReq,
   input  wire logic                    waitrequest
);
   import event_irq_pkg::*;
   logic timedOut = 1'b0;
   initial busReq = '0;
   task automatic access(input logic wr, input logic [4:0] a,
                         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      busReq <= '{a, !wr, wr, d & USED_BITS_MASK};
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 16);
      timedOut = (waitrequest !== 1'b0);
      busReq.read  <= 1'b0;
      busReq.write <= 1'b0;
   endtask : access
endmodule : cpu_bus_model
`default_nettype wire

/* dv/testbench.sv */
// Purpose: Self-checking bench for the event channel interrupt registers
// Assumes: One clock, synchronous active-low reset
// Notes:   Reset checks first, then register rows, event cases after
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import event_irq_pkg::*;
   typedef struct packed {
      logic        wr;
      logic [4:0]  a;
      logic [31:0] d;
   } row_t;
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   bus_req_t     busReq;
   logic [31:0]  readdata;
   logic         waitrequest;
   logic         irqOut;
   chan_events_t ev = '0;
   int           error_cnt = 0;
   int           num_checks = 0;
   // Read rows carry the expected word in d
   row_t rows [8] = '{'{1'b1, 5'h14, 32'hFFFFFFFF},
                      '{1'b0, 5'h10, 32'h0F0FFFFF},
                      '{1'b1, 5'h10, 32'h01010101},
                      '{1'b0, 5'h14, 32'h0E0EFEFE},
                      '{1'b1, 5'h14, 32'h00000000},
                      '{1'b0, 5'h10, 32'h0E0EFEFE},
                      '{1'b1, 5'h1C, 32'hFFFFFFFF},
                      '{1'b0, 5'h1C, 32'h00000000}};
   always #20 clk = ~clk;
   event_channel_irq_regs event_channel_irq_regs_inst (
      .clk(clk), .rst_n(rst_n), .busReq(busReq), .readdata(readdata),
      .waitrequest(waitrequest), .chanEvents(ev), .irqOut(irqOut));
   cpu_bus_model cpu_bus_model_inst (
      .clk(clk), .busReq(busReq), .waitrequest(waitrequest));
   task automatic results();
      $display("Checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input row_t r);
      cpu_bus_model_inst.access(r.wr, r.a, r.d);
      if (cpu_bus_model_inst.timedOut) begin
         error_cnt++;
         results();
      end
      if (!r.wr) chk(readdata, r.d);
   endtask : acc
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      acc('{1'b0, OFFS_FLAGS, RESET_FLAGS});
      acc('{1'b0, OFFS_ENABLE_SET, RESET_ENABLE});
      chk(irqOut, 32'h0);
      $display("Reset test done");
      foreach (rows[i]) acc(rows[i]);
      $display("Row test done");
      @(posedge clk);
      // Channel 0 is asynchronous and must stay quiet
      ev <= '{12'h101, 12'h009, 12'h001};
      @(posedge clk);
      ev <= '0;
      #1 chk(irqOut, 32'h1);
      acc('{1'b0, OFFS_FLAGS, 32'h01000008});
      acc('{1'b1, OFFS_ENABLE_CLR, 32'h00000008});
      #1 chk(irqOut, 32'h0);
      acc('{1'b1, OFFS_FLAGS, 32'h01000008});
      acc('{1'b0, OFFS_FLAGS, 32'h00000000});
      // Event on channel 1 lands in the cycle its clear takes effect
      fork
         acc('{1'b1, OFFS_FLAGS, 32'h00000200});
         begin
            repeat (2) @(posedge clk);
            ev <= '{12'h002, 12'h000, 12'h000};
            @(posedge clk);
            ev <= '0;
         end
      join
      acc('{1'b0, OFFS_FLAGS, 32'h00000200});
      chk(irqOut, 32'h1);
      $display("Event test done");
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      acc('{1'b0, OFFS_FLAGS, RESET_FLAGS});
      acc('{1'b0, OFFS_ENABLE_CLR, RESET_ENABLE});
      chk(irqOut, 32'h0);
      $display("Mid-run reset test done");
      results();
   end
endmodule : testbench
`default_nettype wire
